//--- ifs_bus_master.sv
// Two-wire bus master model that talks to the slave under test
`timescale 1ns/1ps
`default_nettype none
module ifs_bus_master (
  input  wire logic clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic m_scl = 1'b1; // Master clock drive, released when idle
  logic m_sda = 1'b1; // Master data drive, released when idle

  // Wired-and lines with pull-ups; the clock stands high between frames
  assign scl_in = m_scl & ~scl_oe;
  assign sda_in = m_sda & ~sda_oe;

  // Half of the 80 ns link clock period
  task automatic half();
    repeat (5) @(posedge clk);
  endtask : half

  // One bit: set data while low, wait out any stretching, sample at end of high;
  // five clocks low and five high make the 80 ns link period
  task automatic pulse(input logic v, output logic b);
    @(posedge clk);
    m_sda <= v;
    repeat (4) @(posedge clk);
    m_scl <= 1'b1;
    do @(posedge clk); while (!scl_in);
    repeat (4) @(posedge clk);
    b = sda_in;
    m_scl <= 1'b0;
  endtask : pulse

  // Data falls while the clock is high
  task automatic start();
    m_sda <= 1'b0;
    half();
    m_scl <= 1'b0;
  endtask : start

  // Data rises while the clock is high
  task automatic stop();
    @(posedge clk);
    m_sda <= 1'b0;
    half();
    m_scl <= 1'b1;
    half();
    m_sda <= 1'b1;
    half();
  endtask : stop

  // Eight bits MSB first, then the ninth phase with the line released
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) pulse(d[i], q[i]);
    pulse(1'b1, a);
  endtask : xbyte
endmodule : ifs_bus_master
`default_nettype wire

//--- ifs_fifo.sv
// Sixteen-entry byte FIFO with synchronous flush
`timescale 1ns/1ps
`default_nettype none
`include "ifs_map.svh"
module ifs_fifo (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire ifs_pkg::ifs_byte_t din,
  input  wire logic             pop,
  output ifs_pkg::ifs_byte_t    dout,
  output ifs_pkg::ifs_level_t   level,
  output logic                  full,
  output logic                  empty
);
  import ifs_pkg::*;
  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  ifs_byte_t  mem [`IFS_DEPTH];   // Entry storage
  logic [3:0] wp_reg;             // Write pointer
  logic [3:0] rp_reg;             // Read pointer
  ifs_level_t cnt_reg;            // Entries held
  wire        do_push;            // Accepted push
  wire        do_pop;             // Accepted pop
  assign full    = (cnt_reg == 5'(`IFS_DEPTH));
  assign empty   = (cnt_reg == 5'h00);
  assign do_push = push & ~full & ~clear;
  assign do_pop  = pop & ~empty & ~clear;
  assign dout    = mem[rp_reg];
  assign level   = cnt_reg;
  // Data write; storage needs no reset
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_reg] <= din;
    end
  end
  // Pointers and count; flush wins over traffic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (clear) begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else begin
      wp_reg  <= wp_reg + 4'(do_push);
      rp_reg  <= rp_reg + 4'(do_pop);
      cnt_reg <= cnt_reg + 5'(do_push) - 5'(do_pop);
    end
  end
endmodule : ifs_fifo
`default_nettype wire

//--- ifs_map.svh
// Register map, field positions, reset values and sizes of the status block
`ifndef IFS_MAP_SVH
`define IFS_MAP_SVH
// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define IFS_A_DATA     8'h10
`define IFS_A_RAW      8'h34
`define IFS_A_RXTL     8'h38
`define IFS_A_TXTL     8'h3c
`define IFS_A_CLR_RXU  8'h44
`define IFS_A_CLR_RXO  8'h48
`define IFS_A_CLR_TXO  8'h4c
`define IFS_A_CLR_RDQ  8'h50
`define IFS_A_CLR_ABT  8'h54
`define IFS_A_ENABLE   8'h6c
`define IFS_A_OWNADR   8'h70
`define IFS_A_CAUSE    8'h80
// ----------------------------------------------------------------
// Raw status bit positions
// ----------------------------------------------------------------
`define IFS_B_RXU  0
`define IFS_B_RXO  1
`define IFS_B_RXF  2
`define IFS_B_TXO  3
`define IFS_B_TXE  4
`define IFS_B_RDQ  5
`define IFS_B_ABT  6
// ----------------------------------------------------------------
// Reset values, limits and sizes
// ----------------------------------------------------------------
`define IFS_TL_RST   4'h7
`define IFS_TL_MAX   4'hf
`define IFS_OWN_RST  7'h55
`define IFS_DEPTH    16
`define IFS_BIT_LAST 3'h7
`endif

//--- ifs_pkg.sv
// Types shared by the status block files
package ifs_pkg;
  // Serial slave engine states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AEND  = 9'h004,
    ST_ACK   = 9'h008,
    ST_WR    = 9'h010,
    ST_WEND  = 9'h020,
    ST_RWAIT = 9'h040,
    ST_RD    = 9'h080,
    ST_RACK  = 9'h100
  } ifs_state_t;
  typedef logic [7:0] ifs_byte_t;
  typedef logic [4:0] ifs_level_t;
endpackage : ifs_pkg

//--- ifs_top.sv
// Serial slave with FIFO status flags, thresholds and register bus
//
// Operation
// R1: Set abort flag when transmit cannot finish
// R2: Abort cause register tells why
// R3: Abort flushes both FIFOs
// R4: Set read request when addressed for read
// R5: Hold clock low until software answers
// R6: Software answers by writing a data byte
// R7: Reading clear register drops read request
// R8: Transmit empty while level at/below threshold
// R9: Disable flushes transmit; empty follows activity
// R10: Transmit over on write into full FIFO
// R11: Transmit over holds until activity ends
// R12: Receive full while level at/above threshold
// R13: Disable flushes receive; full drops at once
// R14: Receive over on byte into full FIFO
// R15: Acknowledge extra byte, discard it
// R16: Receive over/under hold until activity ends
// R17: Receive under on data read when empty
// R18: Receive threshold 0..15, reset 7, N+1 entries
// R19: Oversized threshold writes store 15
// R20: Receive FIFO holds 16 entries
// R21: Reserved bits read zero, writes ignored
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ifs_map.svh"
module ifs_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  import ifs_pkg::*;
  // ----------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic [1:0] scl_sy_reg;     // Clock line synchroniser
  logic [1:0] sda_sy_reg;     // Data line synchroniser
  logic       scl_d_reg;      // Clock line, one cycle later
  logic       sda_d_reg;      // Data line, one cycle later
  wire        scl_s = scl_sy_reg[1];
  wire        sda_s = sda_sy_reg[1];
  wire        scl_rise = scl_s & ~scl_d_reg;
  wire        scl_fall = ~scl_s & scl_d_reg;
  wire        start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire        stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // Two stages before any logic looks at the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sy_reg <= 2'h3;
      sda_sy_reg <= 2'h3;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      scl_sy_reg <= {scl_sy_reg[0], scl_in};
      sda_sy_reg <= {sda_sy_reg[0], sda_in};
      scl_d_reg  <= scl_sy_reg[1];
      sda_d_reg  <= sda_sy_reg[1];
    end
  end
  // ----------------------------------------------------------------
  // Register bus decode, one wait cycle per access
  // ----------------------------------------------------------------
  logic       done_reg;        // Second cycle of an access
  logic       enable_reg;      // Controller enable
  logic [3:0] rxtl_reg;        // Receive threshold field
  logic [3:0] txtl_reg;        // Transmit threshold field
  logic [6:0] own_reg;         // Own slave address
  wire        req = read | write;
  wire        acc = req & done_reg;
  wire        acc_rd = acc & read;
  wire        acc_wr = acc & write & byteenable[0];
  wire        a_data = (address == `IFS_A_DATA);
  wire        a_raw = (address == `IFS_A_RAW);
  wire        a_rxtl = (address == `IFS_A_RXTL);
  wire        a_txtl = (address == `IFS_A_TXTL);
  wire        a_en = (address == `IFS_A_ENABLE);
  wire        a_own = (address == `IFS_A_OWNADR);
  wire        a_cause = (address == `IFS_A_CAUSE);
  wire        big_val = |writedata[31:4];
  wire [3:0]  tl_val = big_val ? `IFS_TL_MAX : writedata[3:0]; // R19
  assign waitrequest = req & ~done_reg;
  // Access sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= req & ~done_reg;
    end
  end
  // Software-written control; upper bits are dropped, except that threshold writes with upper bits set store 15
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= 1'b0;
      rxtl_reg   <= `IFS_TL_RST; // R18
      txtl_reg   <= `IFS_TL_RST;
      own_reg    <= `IFS_OWN_RST;
    end else if (acc_wr) begin
      if (a_en) enable_reg <= writedata[0];
      if (a_rxtl) rxtl_reg <= tl_val; // R18 R21
      if (a_txtl) txtl_reg <= tl_val;
      if (a_own) own_reg <= writedata[6:0];
    end
  end
  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  ifs_byte_t  rx_dout;        // Receive head
  ifs_byte_t  tx_dout;        // Transmit head
  ifs_level_t rx_lvl;         // Receive entries
  ifs_level_t tx_lvl;         // Transmit entries
  logic       rx_full_f;      // Receive FIFO full
  logic       rx_emp;         // Receive FIFO empty
  logic       tx_full_f;      // Transmit FIFO full
  logic       tx_emp;         // Transmit FIFO empty
  logic       rx_push;        // Engine pushes a byte
  logic       tx_pop;         // Engine takes a byte
  logic       abort_set;      // Transmit abort event
  ifs_byte_t  shift_next;     // Engine shift value
  wire        fl_clr = abort_set | ~enable_reg; // R3 R9 R13
  wire        sw_push = acc_wr & a_data;        // R6
  wire        sw_pop = acc_rd & a_data;
  ifs_fifo u_rx (   // R20
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (fl_clr),
    .push    (rx_push),
    .din     (shift_next),
    .pop     (sw_pop),
    .dout    (rx_dout),
    .level   (rx_lvl),
    .full    (rx_full_f),
    .empty   (rx_emp)
  );
  ifs_fifo u_tx (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (fl_clr),
    .push    (sw_push),
    .din     (writedata[7:0]),
    .pop     (tx_pop),
    .dout    (tx_dout),
    .level   (tx_lvl),
    .full    (tx_full_f),
    .empty   (tx_emp)
  );
  // ----------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------
  ifs_state_t st_reg;         // Engine state
  ifs_state_t st_next;
  ifs_byte_t  shift_reg;      // Byte shifter
  logic [2:0] cnt_reg;        // Bit counter
  logic [2:0] cnt_next;
  logic       rw_reg;         // Master reads from us
  logic       rw_next;
  logic       nack_reg;       // Master refused last byte
  logic       nack_next;
  logic       sda_oe_reg;     // Data line pulled low
  logic       sda_oe_next;
  logic       lead_reg;       // Clock held one cycle after a byte load
  logic [1:0] cause_set;      // Abort reasons this cycle
  wire        active = (st_reg != ST_IDLE);
  wire        in_read = rw_reg & (st_reg == ST_RWAIT | st_reg == ST_RD | st_reg == ST_RACK);
  wire        rdq_set = (st_next == ST_RWAIT) & (st_reg != ST_RWAIT); // R4
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  // Clock stays low until the first data bit has settled; releasing it
  // earlier would move data under a high clock and look like a START
  assign scl_oe  = (st_reg == ST_RWAIT) | lead_reg; // R5
  assign abort_set = |cause_set; // R1
  // Next state of the engine
  always_comb begin
    st_next     = st_reg;
    shift_next  = shift_reg;
    cnt_next    = cnt_reg;
    rw_next     = rw_reg;
    nack_next   = nack_reg;
    sda_oe_next = sda_oe_reg;
    rx_push     = 1'b0;
    tx_pop      = 1'b0;
    cause_set   = 2'b00;
    if (start_c | stop_c) begin
      // Frame edge; a read left with data pending is aborted
      cause_set[1] = in_read & ~tx_emp; // R1
      st_next      = (start_c & enable_reg) ? ST_ADDR : ST_IDLE;
      cnt_next     = 3'h0;
      rw_next      = 1'b0;
      sda_oe_next  = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR: begin
          // Sample one bit per rising clock edge
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == `IFS_BIT_LAST) begin
              st_next = (st_reg == ST_ADDR) ? ST_AEND : ST_WEND;
              rx_push = (st_reg == ST_WR); // R14 R15
            end
          end
        end
        ST_AEND: begin
          // Acknowledge only our own address
          if (scl_fall) begin
            if (shift_reg[7:1] == own_reg) begin
              rw_next     = shift_reg[0];
              sda_oe_next = 1'b1;
              st_next     = ST_ACK;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        ST_WEND: begin
          // Every byte is acknowledged, stored or not
          if (scl_fall) begin
            sda_oe_next = 1'b1; // R15
            st_next     = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            cnt_next    = 3'h0;
            st_next     = rw_reg ? ST_RWAIT : ST_WR;
          end
        end
        ST_RWAIT: begin
          // Clock stretched until a byte is queued
          if (!tx_emp) begin
            shift_next  = tx_dout;
            tx_pop      = 1'b1;
            sda_oe_next = ~tx_dout[7];
            cnt_next    = 3'h0;
            st_next     = ST_RD;
          end
        end
        ST_RD: begin
          // Present the next bit after each falling edge
          if (scl_fall) begin
            shift_next = {shift_reg[6:0], 1'b0};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == `IFS_BIT_LAST) begin
              sda_oe_next = 1'b0;
              st_next     = ST_RACK;
            end else begin
              sda_oe_next = ~shift_reg[6];
            end
          end
        end
        ST_RACK: begin
          // Master answer sampled on rise, acted on at fall
          if (scl_rise) begin
            nack_next = sda_s;
          end
          if (scl_fall) begin
            st_next      = nack_reg ? ST_IDLE : ST_RWAIT;
            cause_set[0] = nack_reg & ~tx_emp; // R1
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end
  // Engine state flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg     <= ST_IDLE;
      shift_reg  <= 8'h00;
      cnt_reg    <= 3'h0;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
      lead_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      shift_reg  <= shift_next;
      cnt_reg    <= cnt_next;
      rw_reg     <= rw_next;
      nack_reg   <= nack_next;
      sda_oe_reg <= sda_oe_next;
      lead_reg   <= tx_pop;
    end
  end
  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic       txo_reg;        // Transmit over
  logic       rxo_reg;        // Receive over
  logic       rxu_reg;        // Receive under
  logic       rdq_reg;        // Read request
  logic       abt_reg;        // Transmit abort
  logic [1:0] cause_reg;      // Abort cause
  wire        idle_off = ~enable_reg & ~active; // R11 R16
  wire        clr_txo = (acc_rd & address == `IFS_A_CLR_TXO) | idle_off;
  wire        clr_rxo = (acc_rd & address == `IFS_A_CLR_RXO) | idle_off;
  wire        clr_rxu = (acc_rd & address == `IFS_A_CLR_RXU) | idle_off;
  wire        clr_rdq = acc_rd & address == `IFS_A_CLR_RDQ; // R7
  wire        clr_abt = acc_rd & address == `IFS_A_CLR_ABT;
  wire        set_txo = sw_push & tx_full_f; // R10
  wire        set_rxo = rx_push & rx_full_f & ~fl_clr; // R14
  wire        set_rxu = sw_pop & rx_emp; // R17
  wire        txe = enable_reg ? (tx_lvl <= {1'b0, txtl_reg}) : active; // R8 R9
  wire        rxf = enable_reg & (rx_lvl > {1'b0, rxtl_reg}); // R12 R13 R18
  wire [31:0] raw = {25'h0, abt_reg, rdq_reg, txe, txo_reg, rxf, rxo_reg, rxu_reg};
  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txo_reg   <= 1'b0;
      rxo_reg   <= 1'b0;
      rxu_reg   <= 1'b0;
      rdq_reg   <= 1'b0;
      abt_reg   <= 1'b0;
      cause_reg <= 2'b00;
    end else begin
      txo_reg   <= set_txo | (txo_reg & ~clr_txo); // R10 R11
      rxo_reg   <= set_rxo | (rxo_reg & ~clr_rxo); // R16
      rxu_reg   <= set_rxu | (rxu_reg & ~clr_rxu); // R16
      rdq_reg   <= rdq_set | (rdq_reg & ~clr_rdq); // R4 R7
      abt_reg   <= abort_set | (abt_reg & ~clr_abt); // R1
      cause_reg <= cause_set | (cause_reg & {2{~clr_abt}}); // R2
    end
  end
  // ----------------------------------------------------------------
  // Read data, loaded in the first cycle of an access
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = a_data  ? {24'h0, rx_dout} :
                       a_raw   ? raw :
                       a_rxtl  ? {28'h0, rxtl_reg} : // R21
                       a_txtl  ? {28'h0, txtl_reg} :
                       a_en    ? {31'h0, enable_reg} :
                       a_own   ? {25'h0, own_reg} :
                       a_cause ? {30'h0, cause_reg} : 32'h0;
  // Read data register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0;
    end else if (read & ~done_reg) begin
      readdata <= rd_mux;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_first_cycle;
    req & ~done_reg;
  endsequence
  sequence s_push_full;
    rx_push & rx_full_f & enable_reg & ~abort_set & ~sw_pop;
  endsequence
  a_abort_flush: assert property (abort_set |=> rx_emp & tx_emp & abt_reg) // R3
    else $error("abort did not flush FIFOs");
  a_rdq_raise: assert property ($rose(st_reg == ST_RWAIT) |-> rdq_reg) // R4
    else $error("read request not raised");
  a_clock_hold: assert property (st_reg == ST_RWAIT & tx_emp & ~start_c & ~stop_c |-> scl_oe ##1 st_reg == ST_RWAIT) // R5
    else $error("clock not stretched");
  a_rdq_clear: assert property (clr_rdq & ~rdq_set |=> ~rdq_reg) // R7
    else $error("read request not cleared");
  a_txe_off: assert property (~enable_reg |-> raw[`IFS_B_TXE] == active) // R9
    else $error("transmit empty wrong while disabled");
  a_txo_set: assert property (s_first_cycle ##1 set_txo |=> txo_reg) // R10
    else $error("transmit over not set");
  a_rxf_drop: assert property ($fell(enable_reg) |-> ~raw[`IFS_B_RXF] ##1 rx_emp) // R13
    else $error("receive full not dropped");
  a_rx_discard: assert property (s_push_full |=> rxo_reg & rx_lvl == 5'(`IFS_DEPTH)) // R14
    else $error("overflow byte not discarded");
  a_over_hold: assert property (~enable_reg & active & ~clr_rxo & ~clr_rxu |=>
    (rxo_reg | ~$past(rxo_reg)) & (rxu_reg | ~$past(rxu_reg))) // R16
    else $error("receive over lost while active");
  a_under_set: assert property (s_first_cycle ##1 set_rxu |=> rxu_reg) // R17
    else $error("receive under not set");
  a_tl_clamp: assert property (acc_wr & a_rxtl & big_val |=> rxtl_reg == `IFS_TL_MAX) // R19
    else $error("threshold not clamped");
  a_wait_once: assert property (s_first_cycle |-> waitrequest ##1 ~waitrequest) // One wait cycle per access
    else $error("bus answer timing wrong");
endmodule : ifs_top
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the FIFO status block
`timescale 1ns/1ps
`default_nettype none
`include "ifs_map.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  address = 8'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  int          bad_count = 0;
  int          checks = 0;
  int          seed = 32'h19431a83;
  logic [63:0] expq[$];   // Pending reads as mask and expected value
  logic [63:0] note;      // Oldest pending read
  logic [7:0]  rx_b[17];  // Bytes sent by the bus master
  logic [7:0]  q;         // Byte seen by the bus master
  logic        a;         // Ninth-phase level seen by the bus master
  logic [3:0]  thr;       // Receive threshold under test
  localparam logic [31:0] all_m = 32'hffffffff;
  localparam logic [31:0] m_rxu = 32'h1 << `IFS_B_RXU;
  localparam logic [31:0] m_rxo = 32'h1 << `IFS_B_RXO;
  localparam logic [31:0] m_rxf = 32'h1 << `IFS_B_RXF;
  localparam logic [31:0] m_txo = 32'h1 << `IFS_B_TXO;
  localparam logic [31:0] m_txe = 32'h1 << `IFS_B_TXE;
  localparam logic [31:0] m_rdq = 32'h1 << `IFS_B_RDQ;
  localparam logic [31:0] m_abt = 32'h1 << `IFS_B_ABT;

  initial forever #4 clk = ~clk;

  ifs_top ifs_top_inst (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
  ifs_bus_master ms (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in),
    .sda_in(sda_in));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic rd_en, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    read <= rd_en;
    write <= !rd_en;
    address <= ad;
    writedata <= d;
    do @(posedge clk); while (waitrequest);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b0, ad, d);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    expq.push_back({m, e});
    bus(1'b1, ad, 32'h0);
  endtask : rd

  // Takes the oldest note whenever read data is handed over
  always @(posedge clk) begin
    if (read && !waitrequest) begin
      if (expq.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        note = expq.pop_front();
        chk(readdata & note[63:32], note[31:0]);
      end
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(`IFS_A_RXTL, all_m, 32'h7);
    rd(`IFS_A_RAW, all_m, 32'h0);
    rd(8'h00, all_m, 32'h0);
    wr(`IFS_A_RXTL, 32'h3);
    rd(`IFS_A_RXTL, all_m, 32'h3);
    wr(`IFS_A_RXTL, 32'hfffffff2);
    rd(`IFS_A_RXTL, all_m, 32'hf);
    byteenable <= 4'he;
    wr(`IFS_A_RXTL, 32'h1);
    byteenable <= 4'hf;
    rd(`IFS_A_RXTL, all_m, 32'hf);
    // Underflow on an empty data read
    wr(`IFS_A_ENABLE, 32'h1);
    rd(`IFS_A_DATA, 32'h0, 32'h0);
    rd(`IFS_A_RAW, m_rxu | m_txe, m_rxu | m_txe);
    rd(`IFS_A_CLR_RXU, all_m, 32'h0);
    rd(`IFS_A_RAW, m_rxu, 32'h0);
    // Fill the transmit side past its depth
    for (int i = 1; i <= 17; i++) begin
      wr(`IFS_A_DATA, {24'h0, 8'($random(seed))});
      rd(`IFS_A_RAW, m_txe | m_txo, (i <= 7 ? m_txe : 32'h0) | (i > 16 ? m_txo : 32'h0));
    end
    wr(`IFS_A_ENABLE, 32'h0);
    rd(`IFS_A_RAW, m_txe | m_txo, 32'h0);
    wr(`IFS_A_ENABLE, 32'h1);
    // Serial write of seventeen bytes into the receive side
    thr = 4'($random(seed));
    wr(`IFS_A_RXTL, {28'h0, thr});
    ms.start();
    ms.xbyte({`IFS_OWN_RST, 1'b0}, q, a);
    for (int i = 0; i < 17; i++) begin
      rx_b[i] = 8'($random(seed));
      ms.xbyte(rx_b[i], q, a);
      chk({31'h0, a}, 32'h0);
    end
    ms.stop();
    rd(`IFS_A_RAW, m_rxo, m_rxo);
    rd(`IFS_A_CLR_RXO, all_m, 32'h0);
    for (int l = 16; l > 0; l--) begin
      rd(`IFS_A_RAW, m_rxf, (l > thr) ? m_rxf : 32'h0);
      rd(`IFS_A_DATA, 32'hff, {24'h0, rx_b[16 - l]});
    end
    rd(`IFS_A_DATA, 32'h0, 32'h0);
    wr(`IFS_A_RXTL, 32'h0);
    ms.start();
    ms.xbyte({`IFS_OWN_RST, 1'b0}, q, a);
    ms.xbyte(rx_b[0], q, a);
    ms.stop();
    rd(`IFS_A_RAW, m_rxf | m_rxu, m_rxf | m_rxu);
    wr(`IFS_A_ENABLE, 32'h0);
    rd(`IFS_A_RAW, m_rxf | m_rxu, 32'h0);
    wr(`IFS_A_ENABLE, 32'h1);
    // Remote read: stretch, service, then a NACK with data still queued
    wr(`IFS_A_TXTL, 32'h0);
    fork
      begin
        ms.start();
        ms.xbyte({`IFS_OWN_RST, 1'b1}, q, a);
        ms.xbyte(8'hff, q, a);
        ms.stop();
      end
      begin
        for (int k = 0; k < 3000 && scl_oe !== 1'b1; k++) @(posedge clk);
        chk({31'h0, scl_oe}, 32'h1);
        rd(`IFS_A_RAW, m_rdq, m_rdq);
        rd(`IFS_A_CLR_RDQ, all_m, 32'h0);
        rd(`IFS_A_RAW, m_rdq, 32'h0);
        wr(`IFS_A_DATA, {24'h0, rx_b[1]});
        wr(`IFS_A_DATA, {24'h0, rx_b[2]});
      end
    join
    chk({24'h0, q}, {24'h0, rx_b[1]});
    rd(`IFS_A_RAW, m_abt | m_txe, m_abt | m_txe);
    rd(`IFS_A_CAUSE, 32'h3, 32'h1);
    rd(`IFS_A_CLR_ABT, all_m, 32'h0);
    rd(`IFS_A_RAW, m_abt, 32'h0);
    // Disable in mid-frame: flags follow bus activity, not the enable bit
    rd(`IFS_A_DATA, 32'h0, 32'h0);
    ms.start();
    ms.xbyte({`IFS_OWN_RST, 1'b0}, q, a);
    wr(`IFS_A_ENABLE, 32'h0);
    rd(`IFS_A_RAW, m_rxu | m_txe, m_rxu | m_txe);
    ms.stop();
    rd(`IFS_A_RAW, m_rxu | m_txe, 32'h0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
